// >>> rtl/rcc_clock_config.sv
// Run-mode clock configuration registers with APB access and clock control outputs.
//
// Notes on behaviour
// R01: Override flag selects extended register's divisor.
// R02: Bit 13 drives PLL power-down directly.
// R03: PLL power-down bit resets to one.
// R04: Bypass one clocks system from oscillator.
// R05: Bypass zero uses divided PLL output.
// R06: Bits 9:6 writable crystal code, reset 0xB.
// R07: Software avoids codes 0-3 with PLL.
// R08: Crystal code decoded by 16-entry table.
// R09: Reserved bits read-only; bit 12 reads one.
// R10: Software preserves reserved bits on writes.
// R11: PLL selected forces system divider use.
// R12: Bits 5:4 choose oscillator source.
`include "rcc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module rcc_clock_config
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output rcc_pkg::rcc_clk_ctl_t clk_ctl,
   output logic auto_clock_gating,
   output logic int_osc_disable,
   output logic main_osc_disable,
   output logic [15:0] crystal_khz
);

   // ========================================
   // Register state
   // ========================================
   logic acg_r;
   logic [3:0] sys_divisor_r;
   logic divider_enable_r;
   logic pll_power_off_r;
   logic bypass_r;
   logic [3:0] crystal_freq_code_r;
   logic [1:0] osc_src_r;
   logic iosc_dis_r;
   logic mosc_dis_r;
   logic ext_config_override_r;
   logic [5:0] ext_sys_divisor_r;
   logic [31:0] cfg_word;
   logic [31:0] ext_word;
   logic [15:0] rom_khz;
   logic wr_cfg;
   logic wr_ext;
   logic hit;
   logic apb_access;

   // ========================================
   // Bus decode
   // ========================================
   // Only the low twelve address bits reach this block; the upper map is decoded
   // upstream, so aliasing above them is the bus fabric's concern.
   function automatic logic sel_cfg(input logic [11:0] a);
      sel_cfg = (a == `RCC_OFF_CFG);
   endfunction

   function automatic logic sel_ext(input logic [11:0] a);
      sel_ext = (a == `RCC_OFF_EXT);
   endfunction

   function automatic logic sel_freq(input logic [11:0] a);
      sel_freq = (a == `RCC_OFF_FREQ);
   endfunction

   // Zero-wait slave: every access completes in its first access cycle.
   // Unmapped offsets answer with an error but still complete in one access cycle.
   assign pready = 1'b1;
   assign apb_access = psel && penable;
   assign hit = sel_cfg(paddr) || sel_ext(paddr) || sel_freq(paddr);
   assign pslverr = apb_access && !hit;
   assign wr_cfg = apb_access && pwrite && sel_cfg(paddr);
   assign wr_ext = apb_access && pwrite && sel_ext(paddr);

   // Reserved bits of the write word are dropped here, so they never reach a field.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acg_r <= 1'b0;
         sys_divisor_r <= `RCC_RST_DIV;
         divider_enable_r <= 1'b0;
         pll_power_off_r <= `RCC_RST_PWR; // [R03]
         bypass_r <= `RCC_RST_BYP; // [R04]
         crystal_freq_code_r <= `RCC_RST_CRYSTAL_FREQ_CODE; // [R06]
         osc_src_r <= `RCC_RST_OSC; // [R12]
         iosc_dis_r <= 1'b0;
         mosc_dis_r <= `RCC_RST_MOSCDIS;
      end
      else if (wr_cfg)
      begin
         acg_r <= pwdata[`RCC_ACG_BIT];
         sys_divisor_r <= pwdata[`RCC_DIV_MSB:`RCC_DIV_LSB];
         divider_enable_r <= pwdata[`RCC_USEDIV_BIT];
         pll_power_off_r <= pwdata[`RCC_PWR_BIT]; // [R02]
         bypass_r <= pwdata[`RCC_BYP_BIT];
         crystal_freq_code_r <= pwdata[`RCC_CRYSTAL_FREQ_CODE_MSB:`RCC_CRYSTAL_FREQ_CODE_LSB]; // [R06]
         osc_src_r <= pwdata[`RCC_OSC_MSB:`RCC_OSC_LSB];
         iosc_dis_r <= pwdata[`RCC_IOSCDIS_BIT];
         mosc_dis_r <= pwdata[`RCC_MOSCDIS_BIT];
      end
   end

   // The extended register only carries the override flag and its wider divisor;
   // its other fields stay with the config register in this block.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Override is off after reset, so the config register's divisor rules.
         ext_config_override_r <= 1'b0;
         ext_sys_divisor_r <= `RCC_RST_EXT_DIV;
      end
      else if (wr_ext)
      begin
         ext_config_override_r <= pwdata[`RCC_EXT_USE_BIT];
         ext_sys_divisor_r <= pwdata[`RCC_EXT_DIV_MSB:`RCC_EXT_DIV_LSB];
      end
   end

   // ========================================
   // Read data
   // ========================================
   always_comb
   begin
      // Reserved positions start at zero and bit 12 is forced high, so writes
      // can never change what they read.
      cfg_word = 32'h0000_0000; // [R09]
      cfg_word[`RCC_ACG_BIT] = acg_r;
      cfg_word[`RCC_DIV_MSB:`RCC_DIV_LSB] = sys_divisor_r;
      cfg_word[`RCC_USEDIV_BIT] = divider_enable_r;
      cfg_word[`RCC_PWR_BIT] = pll_power_off_r;
      cfg_word[`RCC_RSV1_BIT] = 1'b1; // [R09]
      cfg_word[`RCC_BYP_BIT] = bypass_r;
      cfg_word[`RCC_CRYSTAL_FREQ_CODE_MSB:`RCC_CRYSTAL_FREQ_CODE_LSB] = crystal_freq_code_r;
      cfg_word[`RCC_OSC_MSB:`RCC_OSC_LSB] = osc_src_r;
      cfg_word[`RCC_IOSCDIS_BIT] = iosc_dis_r;
      cfg_word[`RCC_MOSCDIS_BIT] = mosc_dis_r;
      ext_word = 32'h0000_0000;
      ext_word[`RCC_EXT_USE_BIT] = ext_config_override_r;
      ext_word[`RCC_EXT_DIV_MSB:`RCC_EXT_DIV_LSB] = ext_sys_divisor_r;
   end

   // Read data is registered in the setup cycle so it is stable for the access phase.
   // The frequency word reads the table as it stands; writes to it are ignored.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         if (sel_cfg(paddr))
            prdata <= cfg_word;
         else if (sel_ext(paddr))
            prdata <= ext_word;
         else if (sel_freq(paddr))
            prdata <= {16'h0000, rom_khz};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // ========================================
   // Clock control
   // ========================================
   // The table is registered, so the frequency follows a code change by two edges.
   rcc_crystal_freq_code_rom u_rom
   (
      .pclk(pclk),
      .presetn(presetn),
      .code(crystal_freq_code_r),
      .freq_khz(rom_khz)
   );

   // Every control output is registered so downstream clock muxes see one clean
   // change per write, at the cost of one cycle of latency.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_ctl <= '0;
         clk_ctl.sys_divisor <= {2'h0, `RCC_RST_DIV};
         clk_ctl.osc_select <= rcc_pkg::RCC_OSC_INT;
         clk_ctl.pll_power_off <= `RCC_RST_PWR;
         auto_clock_gating <= 1'b0;
         int_osc_disable <= 1'b0;
         main_osc_disable <= `RCC_RST_MOSCDIS;
         crystal_khz <= 16'h0000;
      end
      else
      begin
         clk_ctl.sys_from_pll <= !bypass_r; // [R04] [R05]
         // The PLL output always goes through the divider, whatever the enable bit says.
         clk_ctl.divider_used <= divider_enable_r || !bypass_r; // [R11] [R05]
         clk_ctl.sys_divisor <= ext_config_override_r ? ext_sys_divisor_r
                                : {2'h0, sys_divisor_r}; // [R01]
         clk_ctl.osc_select <= rcc_pkg::rcc_osc_t'(osc_src_r); // [R12]
         clk_ctl.pll_power_off <= pll_power_off_r; // [R02]
         // A reserved crystal code with the PLL in use is flagged, not blocked: the
         // register still takes it, since keeping clear of those codes is software's job.
         clk_ctl.pll_code_bad <= !bypass_r && (crystal_freq_code_r < `RCC_CRYSTAL_FREQ_CODE_PLL_MIN); // [R07]
         auto_clock_gating <= acg_r;
         int_osc_disable <= iosc_dis_r;
         main_osc_disable <= mosc_dis_r;
         crystal_khz <= rom_khz; // [R08]
      end
   end

endmodule

`default_nettype wire

// >>> rtl/rcc_crystal_freq_code_rom.sv
// Crystal code to crystal frequency lookup, registered output in kHz.
`timescale 1ns/100ps
`default_nettype none

module rcc_crystal_freq_code_rom
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] code,
   output logic [15:0] freq_khz
);

   // ========================================
   // Lookup
   // ========================================
   // Fractional kilohertz are truncated; the table is informative only.
   function automatic logic [15:0] rcc_code_khz(input logic [3:0] c);
      unique case (c)
         4'h0: rcc_code_khz = 16'd1000;
         4'h1: rcc_code_khz = 16'd1843;
         4'h2: rcc_code_khz = 16'd2000;
         4'h3: rcc_code_khz = 16'd2457;
         4'h4: rcc_code_khz = 16'd3579;
         4'h5: rcc_code_khz = 16'd3686;
         4'h6: rcc_code_khz = 16'd4000;
         4'h7: rcc_code_khz = 16'd4096;
         4'h8: rcc_code_khz = 16'd4915;
         4'h9: rcc_code_khz = 16'd5000;
         4'ha: rcc_code_khz = 16'd5120;
         4'hb: rcc_code_khz = 16'd5120;
         4'hc: rcc_code_khz = 16'd6144;
         4'hd: rcc_code_khz = 16'd7372;
         4'he: rcc_code_khz = 16'd8000;
         4'hf: rcc_code_khz = 16'd8192;
      endcase
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         freq_khz <= 16'h0000;
      else
         freq_khz <= rcc_code_khz(code); // [R08]
   end

endmodule

`default_nettype wire

// >>> rtl/rcc_map.svh
// Register offsets, field positions, reset values and codes of the run-mode clock block.
`ifndef RCC_MAP_SVH
`define RCC_MAP_SVH

`define RCC_OFF_CFG 12'h060
`define RCC_OFF_EXT 12'h070
`define RCC_OFF_FREQ 12'h078

`define RCC_ACG_BIT 27
`define RCC_DIV_LSB 23
`define RCC_DIV_MSB 26
`define RCC_USEDIV_BIT 22
`define RCC_PWR_BIT 13
`define RCC_RSV1_BIT 12
`define RCC_BYP_BIT 11
`define RCC_CRYSTAL_FREQ_CODE_LSB 6
`define RCC_CRYSTAL_FREQ_CODE_MSB 9
`define RCC_OSC_LSB 4
`define RCC_OSC_MSB 5
`define RCC_IOSCDIS_BIT 1
`define RCC_MOSCDIS_BIT 0

`define RCC_EXT_USE_BIT 31
`define RCC_EXT_DIV_LSB 23
`define RCC_EXT_DIV_MSB 28

`define RCC_RST_DIV 4'hf
`define RCC_RST_CRYSTAL_FREQ_CODE 4'hb
`define RCC_RST_OSC 2'h1
`define RCC_RST_PWR 1'h1
`define RCC_RST_BYP 1'h1
`define RCC_RST_MOSCDIS 1'h1
`define RCC_RST_EXT_DIV 6'h0f
`define RCC_CRYSTAL_FREQ_CODE_PLL_MIN 4'h4

`endif

// >>> rtl/rcc_pkg.sv
// Types shared by the run-mode clock configuration block.
package rcc_pkg;

   typedef enum logic [1:0]
   {
      RCC_OSC_MAIN,
      RCC_OSC_INT,
      RCC_OSC_INT_DIV4,
      RCC_OSC_30K
   } rcc_osc_t;

   typedef struct packed
   {
      logic sys_from_pll;
      logic divider_used;
      logic [5:0] sys_divisor;
      rcc_osc_t osc_select;
      logic pll_power_off;
      logic pll_code_bad;
   } rcc_clk_ctl_t;

endpackage

// >>> test/rcc_clock_config_assertions.sv
// Concurrent checks on the run-mode clock configuration block ports.
`timescale 1ns/100ps
`default_nettype none
module rcc_clock_config_chk
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire rcc_pkg::rcc_clk_ctl_t clk_ctl,
   input wire logic auto_clock_gating,
   input wire logic int_osc_disable,
   input wire logic main_osc_disable,
   input wire logic [15:0] crystal_khz
);
   // ======================================================================
   // Register shadow
   // Outputs are judged only from the third edge after a write or a reset, so either latency passes.
   logic [31:0] cfg_m;
   logic [31:0] ext_m;
   logic [1:0] age_r;
   logic [15:0] khz_tab [16] = '{16'h03e8, 16'h0733, 16'h07d0, 16'h0999, 16'h0dfb, 16'h0e66,
      16'h0fa0, 16'h1000, 16'h1333, 16'h1388, 16'h1400, 16'h1400, 16'h1800, 16'h1ccc,
      16'h1f40, 16'h2000};
   wire wr_ok = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg_m <= 32'h07803ad1;
         ext_m <= 32'h07800000;
         age_r <= 2'h0;
      end
      else
      begin
         if (wr_ok && paddr == 12'h060)
            cfg_m <= (pwdata & 32'h0fc02bf3) | 32'h00001000;
         if (wr_ok && paddr == 12'h070)
            ext_m <= pwdata & 32'h9f800000;
         if (wr_ok && (paddr == 12'h060 || paddr == 12'h070))
            age_r <= 2'h0;
         else if (age_r != 2'h3)
            age_r <= age_r + 2'h1;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence settled_s; age_r >= 2'h2; endsequence
   sequence cfg_rd_s; psel && penable && !pwrite && paddr == 12'h060; endsequence
   sequence bad_s; psel && penable && !(paddr inside {12'h060, 12'h070, 12'h078}); endsequence
   pll_power_a: assert property (settled_s |-> clk_ctl.pll_power_off == cfg_m[13])
      else $error("power-down output wrong");
   bypass_sel_a: assert property (settled_s |-> clk_ctl.sys_from_pll == !cfg_m[11])
      else $error("clock source wrong");
   div_force_a: assert property (settled_s |-> clk_ctl.divider_used == (cfg_m[22] | !cfg_m[11]))
      else $error("divider use wrong");
   div_pick_a: assert property (settled_s |-> clk_ctl.sys_divisor ==
      (ext_m[31] ? ext_m[28:23] : {2'h0, cfg_m[26:23]})) else $error("divisor wrong");
   osc_sel_a: assert property (settled_s |-> clk_ctl.osc_select == cfg_m[5:4])
      else $error("oscillator select wrong");
   code_flag_a: assert property (settled_s |-> clk_ctl.pll_code_bad == (!cfg_m[11] && cfg_m[9:6] < 4'h4))
      else $error("crystal code flag wrong");
   cfg_read_a: assert property (cfg_rd_s |-> prdata == cfg_m && !pslverr)
      else $error("config read wrong");
   bad_addr_a: assert property (bad_s |-> pslverr && pready)
      else $error("unmapped access not refused");
   aux_copy_a: assert property (settled_s |-> {auto_clock_gating, int_osc_disable,
      main_osc_disable} == {cfg_m[27], cfg_m[1], cfg_m[0]}) else $error("oscillator bits wrong");
   crystal_khz_a: assert property (settled_s |-> crystal_khz == khz_tab[cfg_m[9:6]])
      else $error("crystal frequency wrong");
endmodule
bind rcc_clock_config rcc_clock_config_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_ctl, .auto_clock_gating,
   .int_osc_disable, .main_osc_disable, .crystal_khz);
`default_nettype wire

// >>> test/rcc_clock_config_bench.sv
// Self-checking bench for the run-mode clock configuration block.
`timescale 1ns/100ps
`default_nettype none
module rcc_clock_config_bench;
   // ======================================================================
   // Stimulus and checking
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] w;
   logic pready;
   logic pslverr;
   logic [32:0] e;
   logic [32:0] exp_q[$];
   rcc_pkg::rcc_clk_ctl_t clk_ctl;
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 19;
   logic [15:0] khz [16] = '{16'h03e8, 16'h0733, 16'h07d0, 16'h0999, 16'h0dfb, 16'h0e66,
      16'h0fa0, 16'h1000, 16'h1333, 16'h1388, 16'h1400, 16'h1400, 16'h1800, 16'h1ccc,
      16'h1f40, 16'h2000};
   rcc_clock_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .clk_ctl, .auto_clock_gating(), .int_osc_disable(),
      .main_osc_disable(), .crystal_khz());
   initial
   begin
      forever #50 pclk = ~pclk;
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] x);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr)
         exp_q.push_back(x);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   always @(posedge pclk)
   begin
      if (psel && penable && !pwrite && pready === 1'b1)
      begin
         e = exp_q.pop_front();
         check_count++;
         if ({pslverr, prdata} !== e)
         begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, {pslverr, prdata}, e);
         end
      end
   end
   task finish_test;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h060, 32'h0, {1'b0, 32'h07803ad1});
      apb(1'b0, 12'h078, 32'h0, {17'h0, khz[11]});
      apb(1'b1, 12'h060, 32'hffffffff, 33'h0);
      apb(1'b0, 12'h060, 32'h0, {1'b0, 32'h0fc03bf3});
      w = $random(seed) | 32'h80000000;
      apb(1'b1, 12'h070, w, 33'h0);
      apb(1'b0, 12'h070, 32'h0, {1'b0, w & 32'h9f800000});
      for (int c = 0; c < 16; c++)
      begin
         w = $random(seed);
         w[9:6] = c[3:0];
         // Codes below four are written only with the PLL bypassed.
         if (c < 4)
            w[11] = 1'b1;
         if (c == 8)
            apb(1'b1, 12'h070, 32'h0, 33'h0);
         apb(1'b1, 12'h060, w, 33'h0);
         repeat (3) @(posedge pclk);
         apb(1'b0, 12'h060, 32'h0, {1'b0, (w & 32'h0fc02bf3) | 32'h00001000});
         apb(1'b0, 12'h078, 32'h0, {17'h0, khz[c]});
      end
      apb(1'b1, 12'h104, w, 33'h0);
      apb(1'b1, 12'h078, w, 33'h0);
      apb(1'b0, 12'h104, 32'h0, {1'b1, 32'h0});
      apb(1'b0, 12'h078, 32'h0, {17'h0, khz[15]});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h060, 32'h0, {1'b0, 32'h07803ad1});
      // Read-modify-write of the reset word that only clears the power-down bit.
      apb(1'b1, 12'h060, 32'h07801ad1, 33'h0);
      apb(1'b0, 12'h060, 32'h0, {1'b0, 32'h07801ad1});
      finish_test();
   end
   initial
   begin
      repeat (1000) @(posedge pclk);
      n_mismatch++;
      finish_test();
   end
endmodule
`default_nettype wire
